// [rtl/pcd_defs.vh]
/*
  Shared constants of the loop reference and post divider block:
  register indices, field positions, write masks, reset values and
  divider widths. Assumes inclusion by bare name from the rtl files.
*/
`ifndef PCD_DEFS_VH
`define PCD_DEFS_VH

// Register indices; the byte address is four times the index
`define PCD_IDX_W 6
`define PCD_IDX_MULT 6'h00
`define PCD_IDX_REF 6'h01
`define PCD_IDX_POST 6'h02
`define PCD_IDX_FLAGS 6'h03
`define PCD_IDX_INT_EN 6'h04
`define PCD_IDX_SRC_SEL 6'h05
`define PCD_IDX_LOOP 6'h06
`define PCD_IDX_RTI 6'h07
`define PCD_IDX_WDOG 6'h08
`define PCD_IDX_TEST_BYP 6'h09
`define PCD_IDX_TEST_CLK 6'h0a
`define PCD_IDX_WDOG_ARM 6'h0b

// Word address bits that carry the index
`define PCD_ADDR_IDX_MSB 7
`define PCD_ADDR_IDX_LSB 2

// Bus encodings
`define PCD_HTRANS_ACT_BIT 1
`define PCD_HRESP_OKAY 1'b0
`define PCD_RDATA_ZERO 32'h0000_0000
`define PCD_BYTE_ZERO 8'h00

// Field positions
`define PCD_REF_DIV_MSB 5
`define PCD_REF_RANGE_MSB 7
`define PCD_REF_RANGE_LSB 6
`define PCD_MULT_MSB 5
`define PCD_VCO_RANGE_MSB 7
`define PCD_VCO_RANGE_LSB 6
`define PCD_POST_MSB 4
`define PCD_SEL_LOOP_BIT 7
`define PCD_LOOP_ON_BIT 6
`define PCD_LOCK_BIT 3

// Writable bits of the mixed registers
`define PCD_POST_MASK 8'h1f
`define PCD_INT_EN_MASK 8'h92
`define PCD_SRC_SEL_MASK 8'hcb
`define PCD_WDOG_MASK 8'hc7

// Reset values
`define PCD_RST_MULT 8'h00
`define PCD_RST_REF 8'h00
`define PCD_RST_POST 8'h00
`define PCD_RST_INT_EN 8'h00
`define PCD_RST_SRC_SEL 8'h00
`define PCD_RST_LOOP 8'h40
`define PCD_RST_RTI 8'h00
`define PCD_RST_WDOG 8'h00

// Divider sizing and lock detector default
`define PCD_DIV_W 7
`define PCD_DIV_ONE 7'h01
`define PCD_LOCK_W 16
`define PCD_LOCK_REF_CYCLES 16'h0010

`endif

// [rtl/pcd_clock_divider.v]
/*
  Edge-counting clock divider. Samples an outside clock pin through a
  three-stage synchroniser and emits a registered divided clock.
  Assumes the source runs well below half the core clock rate.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcd_defs.vh"

module pcd_clock_divider #(
  parameter DIV_W = `PCD_DIV_W
) (
  input wire clk,
  input wire rst,
  input wire src_pin,
  input wire [DIV_W-1:0] div_value,
  output reg div_clk,
  output reg period_tick
);

  reg sync1_r;
  reg sync2_r;
  reg sync3_r;
  reg level_r;
  reg [DIV_W-1:0] cnt_r;
  reg [DIV_W-1:0] div_r;
  reg level_nxt;
  reg [DIV_W-1:0] cnt_nxt;
  reg [DIV_W-1:0] div_nxt;
  reg out_nxt;
  reg [DIV_W:0] half_w;
  wire agree;
  wire rise;
  wire wrap;
  wire [DIV_W-1:0] one_w;

  assign one_w = {{(DIV_W-1){1'b0}}, 1'b1};
  // A change counts only once the last two stages agree
  assign agree = (sync2_r == sync3_r);
  assign rise = agree & sync3_r & ~level_r;
  assign wrap = (cnt_r >= div_r - one_w);

  // New divisor taken only at a period boundary, so no runt pulse
  always @* begin
    level_nxt = agree ? sync3_r : level_r;
    cnt_nxt = cnt_r;
    div_nxt = div_r;
    out_nxt = div_clk;
    if (rise) begin
      if (wrap) begin
        cnt_nxt = {DIV_W{1'b0}};
        div_nxt = div_value;
      end else begin
        cnt_nxt = cnt_r + one_w;
      end
    end
    half_w = ({1'b0, div_nxt} + {1'b0, one_w}) >> 1;
    if (div_nxt == one_w) begin
      out_nxt = level_nxt; // pass-through when dividing by one
    end else if (rise) begin
      out_nxt = ({1'b0, cnt_nxt} < half_w);
    end
  end

  // Synchroniser, counter and registered output
  always @(posedge clk) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      level_r <= 1'b0;
      cnt_r <= {DIV_W{1'b0}};
      div_r <= one_w;
      div_clk <= 1'b0;
      period_tick <= 1'b0;
    end else begin
      sync1_r <= src_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      level_r <= level_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      div_clk <= out_nxt;
      period_tick <= rise & wrap;
    end
  end

endmodule
`default_nettype wire

// [rtl/pcd_top.v]
/*
  Loop reference and post divider block with its register file on an
  AHB-Lite slave port. Assumes a single CORE_CLK domain, HSEL decoded
  by the interconnect from the chip-level base, and oscillator and VCO
  clocks arriving as asynchronous pins well below half CORE_CLK.
*/
// Functional notes
// - Reference divider writes ignored while loop clock is selected.
// - Accepted reference divider write restarts the lock detector.
// - Reference clock equals oscillator clock over divide value plus one.
// - Loop filter setting driven from the reference range field.
// - Output clock is VCO clock over twice the final divide value.
// - Final divide value zero passes the VCO clock undivided.
// - Registers decoded as base plus offsets zero through eleven.
`timescale 1ns/1ps
`default_nettype none
`include "pcd_defs.vh"

module pcd_top #(
  parameter LOCK_W = `PCD_LOCK_W,
  parameter [LOCK_W-1:0] LOCK_REF_CYCLES = `PCD_LOCK_REF_CYCLES
) (
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire HREADYOUT,
  output wire HRESP,
  output reg [31:0] HRDATA,
  input wire OSC_CLK,
  input wire VCO_CLK,
  output wire LOOP_REF_CLK,
  output wire LOOP_OUT_CLK,
  output reg [1:0] LOOP_FILTER_SEL,
  output reg [1:0] VCO_RANGE_SEL,
  output reg [5:0] MULTIPLIER_VALUE,
  output reg LOOP_ENABLE,
  output reg LOOP_CLOCK_SELECTED,
  output reg LOOP_LOCKED
);

  // Bus states, one-hot
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_WR = 4'b0010;
  localparam [3:0] ST_RD_WAIT = 4'b0100;
  localparam [3:0] ST_RD_DONE = 4'b1000;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [`PCD_IDX_W-1:0] idx_r;
  reg [`PCD_IDX_W-1:0] idx_nxt;

  // Register file
  reg [7:0] mult_r;
  reg [7:0] ref_r;
  reg [7:0] post_r;
  reg [7:0] int_en_r;
  reg [7:0] src_sel_r;
  reg [7:0] loop_r;
  reg [7:0] rti_r;
  reg [7:0] wdog_r;
  reg [7:0] rd_byte;

  // Lock detector
  reg [LOCK_W-1:0] lock_cnt_r;
  reg lock_restart_r;
  reg [LOCK_W-1:0] lock_cnt_nxt;
  reg locked_nxt;
  reg [1:0] filter_sel_nxt;
  reg [1:0] vco_range_nxt;
  reg [5:0] mult_value_nxt;
  reg loop_enable_nxt;
  reg clock_sel_nxt;

  wire addr_phase;
  wire wr_now;
  wire ref_wr_ok;
  wire ref_tick;
  wire [`PCD_DIV_W-1:0] ref_div_w;
  wire [`PCD_DIV_W-1:0] post_div_w;
  wire [7:0] wbyte;
  wire [`PCD_IDX_W-1:0] addr_idx;
  wire lock_clear;
  wire lock_done;

  // A transfer is taken only when the bus is ready and we are selected
  assign addr_phase = HSEL & HTRANS[`PCD_HTRANS_ACT_BIT] & HREADY;
  assign addr_idx = HADDR[`PCD_ADDR_IDX_MSB:`PCD_ADDR_IDX_LSB];
  assign wr_now = (state_r == ST_WR);
  assign wbyte = HWDATA[7:0];

  // Reads take one wait state so a read right after a write sees it
  assign HREADYOUT = (state_r != ST_RD_WAIT);
  assign HRESP = `PCD_HRESP_OKAY;

  // Bus sequencing
  always @* begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    case (state_r)
      ST_RD_WAIT: begin
        state_nxt = ST_RD_DONE;
      end
      default: begin
        if (addr_phase) begin
          idx_nxt = addr_idx;
          state_nxt = HWRITE ? ST_WR : ST_RD_WAIT;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_r <= ST_IDLE;
      idx_r <= {`PCD_IDX_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
    end
  end

  // Reference divider writes are locked out while the loop drives the system
  assign ref_wr_ok = wr_now & (idx_r == `PCD_IDX_REF) &
    ~src_sel_r[`PCD_SEL_LOOP_BIT];

  // Register writes in the data phase; byte lane 0 carries the value
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mult_r <= `PCD_RST_MULT;
      ref_r <= `PCD_RST_REF;
      post_r <= `PCD_RST_POST;
      int_en_r <= `PCD_RST_INT_EN;
      src_sel_r <= `PCD_RST_SRC_SEL;
      loop_r <= `PCD_RST_LOOP;
      rti_r <= `PCD_RST_RTI;
      wdog_r <= `PCD_RST_WDOG;
    end else if (wr_now) begin
      if (idx_r == `PCD_IDX_MULT) begin
        mult_r <= wbyte;
      end else if (idx_r == `PCD_IDX_REF) begin
        if (ref_wr_ok) begin
          ref_r <= wbyte;
        end
      end else if (idx_r == `PCD_IDX_POST) begin
        post_r <= wbyte & `PCD_POST_MASK;
      end else if (idx_r == `PCD_IDX_INT_EN) begin
        int_en_r <= wbyte & `PCD_INT_EN_MASK;
      end else if (idx_r == `PCD_IDX_SRC_SEL) begin
        src_sel_r <= wbyte & `PCD_SRC_SEL_MASK;
      end else if (idx_r == `PCD_IDX_LOOP) begin
        loop_r <= wbyte;
      end else if (idx_r == `PCD_IDX_RTI) begin
        rti_r <= wbyte;
      end else if (idx_r == `PCD_IDX_WDOG) begin
        wdog_r <= wbyte & `PCD_WDOG_MASK;
      end
      // Test registers, arm register and holes take no write
    end
  end

  // Read decode; unmapped and test indices answer zero
  always @* begin
    rd_byte = `PCD_BYTE_ZERO;
    if (idx_r == `PCD_IDX_MULT) begin
      rd_byte = mult_r;
    end else if (idx_r == `PCD_IDX_REF) begin
      rd_byte = ref_r;
    end else if (idx_r == `PCD_IDX_POST) begin
      rd_byte = post_r;
    end else if (idx_r == `PCD_IDX_FLAGS) begin
      rd_byte = `PCD_BYTE_ZERO;
      rd_byte[`PCD_LOCK_BIT] = LOOP_LOCKED;
    end else if (idx_r == `PCD_IDX_INT_EN) begin
      rd_byte = int_en_r;
    end else if (idx_r == `PCD_IDX_SRC_SEL) begin
      rd_byte = src_sel_r;
    end else if (idx_r == `PCD_IDX_LOOP) begin
      rd_byte = loop_r;
    end else if (idx_r == `PCD_IDX_RTI) begin
      rd_byte = rti_r;
    end else if (idx_r == `PCD_IDX_WDOG) begin
      rd_byte = wdog_r;
    end else if (idx_r == `PCD_IDX_TEST_BYP) begin
      rd_byte = `PCD_BYTE_ZERO;
    end else if (idx_r == `PCD_IDX_TEST_CLK) begin
      rd_byte = `PCD_BYTE_ZERO;
    end
  end

  // Read data captured during the wait state, held until next read
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      HRDATA <= `PCD_RDATA_ZERO;
    end else if (state_r == ST_RD_WAIT) begin
      HRDATA <= {24'h00_0000, rd_byte};
    end
  end

  // Reference divisor is field plus one, range 1 to 64
  assign ref_div_w = {1'b0, ref_r[`PCD_REF_DIV_MSB:0]} +
    `PCD_DIV_ONE;

  // Final divisor is twice the field, or one when the field is zero
  assign post_div_w = (post_r[`PCD_POST_MSB:0] == 5'h00) ?
    `PCD_DIV_ONE :
    {1'b0, post_r[`PCD_POST_MSB:0], 1'b0};

  // Oscillator to loop reference
  pcd_clock_divider #(
    .DIV_W(`PCD_DIV_W)
  ) u_ref_div (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .src_pin(OSC_CLK),
    .div_value(ref_div_w),
    .div_clk(LOOP_REF_CLK),
    .period_tick(ref_tick)
  );

  // VCO to loop output clock
  pcd_clock_divider #(
    .DIV_W(`PCD_DIV_W)
  ) u_post_div (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .src_pin(VCO_CLK),
    .div_value(post_div_w),
    .div_clk(LOOP_OUT_CLK),
    .period_tick()
  );

  // Restart sources of the lock detector
  assign lock_clear = ref_wr_ok | lock_restart_r |
    ~loop_r[`PCD_LOOP_ON_BIT];
  assign lock_done = (lock_cnt_r == LOCK_REF_CYCLES);

  // Lock next state; a restart outranks the lock event on purpose
  always @* begin
    lock_cnt_nxt = lock_cnt_r;
    locked_nxt = LOOP_LOCKED;
    if (lock_clear) begin
      lock_cnt_nxt = {LOCK_W{1'b0}};
      locked_nxt = 1'b0;
    end else if (lock_done) begin
      locked_nxt = 1'b1;
    end else if (ref_tick) begin
      lock_cnt_nxt = lock_cnt_r + {{(LOCK_W-1){1'b0}}, 1'b1};
    end
  end

  // Lock detector: counts reference periods since its last restart.
  // A digital stand-in only; the analogue phase comparison lives outside.
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      lock_cnt_r <= {LOCK_W{1'b0}};
      lock_restart_r <= 1'b0;
      LOOP_LOCKED <= 1'b0;
    end else begin
      lock_restart_r <= ref_wr_ok;
      lock_cnt_r <= lock_cnt_nxt;
      LOOP_LOCKED <= locked_nxt;
    end
  end

  // Analogue loop controls taken straight from the fields
  always @* begin
    // Wrong range may leave the loop unlocked; not checked here
    filter_sel_nxt = ref_r[`PCD_REF_RANGE_MSB:`PCD_REF_RANGE_LSB];
    vco_range_nxt = mult_r[`PCD_VCO_RANGE_MSB:`PCD_VCO_RANGE_LSB];
    mult_value_nxt = mult_r[`PCD_MULT_MSB:0];
    loop_enable_nxt = loop_r[`PCD_LOOP_ON_BIT];
    clock_sel_nxt = src_sel_r[`PCD_SEL_LOOP_BIT];
  end

  // Registered so the analogue controls never see decode glitches
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      LOOP_FILTER_SEL <= 2'h0;
      VCO_RANGE_SEL <= 2'h0;
      MULTIPLIER_VALUE <= 6'h00;
      LOOP_ENABLE <= 1'b0;
      LOOP_CLOCK_SELECTED <= 1'b0;
    end else begin
      LOOP_FILTER_SEL <= filter_sel_nxt;
      VCO_RANGE_SEL <= vco_range_nxt;
      MULTIPLIER_VALUE <= mult_value_nxt;
      LOOP_ENABLE <= loop_enable_nxt;
      LOOP_CLOCK_SELECTED <= clock_sel_nxt;
    end
  end

endmodule
`default_nettype wire

// [verif/pcd_top_sva.sv]
/*
  Checker for the divider block: bus timing, test register reads,
  reference divider gating, lock restart and divided clock shapes.
  Assumes binding to pcd_top, one CORE_CLK domain, HREADY tied to
  HREADYOUT, and source pins slower than a sixth of CORE_CLK.
*/
`timescale 1ns/1ps
`default_nettype none

module pcd_top_sva #(
  parameter LOCK_W = 16,
  parameter [LOCK_W-1:0] LOCK_REF_CYCLES = 16'h0010
) (
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire HREADYOUT,
  input wire HRESP,
  input wire [31:0] HRDATA,
  input wire LOOP_REF_CLK,
  input wire LOOP_OUT_CLK,
  input wire [1:0] LOOP_FILTER_SEL,
  input wire LOOP_ENABLE,
  input wire LOOP_CLOCK_SELECTED,
  input wire LOOP_LOCKED
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  // Address phase accepted at this edge
  wire taken = HSEL && HTRANS[1] && HREADY;
  wire [5:0] idx = HADDR[7:2];

  sequence s_read_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  sequence s_ref_write;
    taken && HWRITE && idx == 6'h01;
  endsequence
  // The gate acts in the data phase and shows on the pin one edge later
  sequence s_ref_write_gated;
    s_ref_write ##2 LOOP_CLOCK_SELECTED;
  endsequence
  sequence s_ref_write_open;
    s_ref_write ##2 !LOOP_CLOCK_SELECTED;
  endsequence

  AST_HRESP_OKAY: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
  AST_WRITE_NO_WAIT: assert property (
    taken && HWRITE |=> HREADYOUT)
    else $error("write data phase stalled");
  AST_READ_ONE_WAIT: assert property (
    taken && !HWRITE |=> s_read_wait)
    else $error("read wait cycle wrong");
  AST_TEST_READ_ZERO: assert property (taken && !HWRITE &&
    (idx == 6'h09 || idx == 6'h0a) |-> ##2 HRDATA == 32'h0000_0000)
    else $error("test register read not zero");
  // Selected loop clock must freeze the range field
  AST_REF_GATED: assert property (
    s_ref_write_gated |=> $stable(LOOP_FILTER_SEL) [*2])
    else $error("reference write not ignored");
  AST_LOCK_RESTART: assert property (
    s_ref_write_open |-> !LOOP_LOCKED [*2])
    else $error("lock not restarted");
  AST_LOCK_NEEDS_LOOP: assert property (
    $rose(LOOP_LOCKED) |-> $past(LOOP_ENABLE))
    else $error("lock without loop enabled");
  // Reference clock high pulses and output clock low pulses never shorter than three core cycles
  AST_REF_NO_GLITCH: assert property (
    $rose(LOOP_REF_CLK) |=> LOOP_REF_CLK [*2])
    else $error("reference clock glitch");
  AST_OUT_NO_GLITCH: assert property (
    $fell(LOOP_OUT_CLK) |=> !LOOP_OUT_CLK [*2])
    else $error("loop output clock glitch");
endmodule

bind pcd_top pcd_top_sva #(
  .LOCK_W(LOCK_W),
  .LOCK_REF_CYCLES(LOCK_REF_CYCLES)
) i_sva (
  .CORE_CLK(CORE_CLK),
  .SYS_RST(SYS_RST),
  .HSEL(HSEL),
  .HADDR(HADDR),
  .HTRANS(HTRANS),
  .HWRITE(HWRITE),
  .HREADY(HREADY),
  .HREADYOUT(HREADYOUT),
  .HRESP(HRESP),
  .HRDATA(HRDATA),
  .LOOP_REF_CLK(LOOP_REF_CLK),
  .LOOP_OUT_CLK(LOOP_OUT_CLK),
  .LOOP_FILTER_SEL(LOOP_FILTER_SEL),
  .LOOP_ENABLE(LOOP_ENABLE),
  .LOOP_CLOCK_SELECTED(LOOP_CLOCK_SELECTED),
  .LOOP_LOCKED(LOOP_LOCKED)
);

`default_nettype wire

// [verif/pll_reference_post_dividers_test.sv]
/*
  Self-checking bench for the divider block: register map, gating,
  divide ratios and lock restart. Assumes pcd_top with its AHB-Lite
  slave as the only slave, and a small lock count for short runs.
*/
`timescale 1ns/1ps
`default_nettype none

module pll_reference_post_dividers_test;
  reg CORE_CLK = 1'b0;
  reg SYS_RST = 1'b1;
  reg HSEL = 1'b0;
  reg [31:0] HADDR = 32'h0000_0000;
  reg [1:0] HTRANS = 2'h0;
  reg HWRITE = 1'b0;
  reg [31:0] HWDATA = 32'h0000_0000;
  reg OSC_CLK = 1'b0;
  reg VCO_CLK = 1'b0;
  reg osc_on = 1'b0;
  reg rd_phase = 1'b0;
  reg [7:0] d;
  reg [31:0] exp_q[$];
  integer n_errors = 0;
  integer n_compared = 0;
  integer seed = 12007;
  integer i;
  integer c;
  wire HREADYOUT, HRESP, LOOP_REF_CLK, LOOP_OUT_CLK, LOOP_LOCKED;
  wire [31:0] HRDATA;
  wire [1:0] LOOP_FILTER_SEL;
  wire [1:0] VCO_RANGE_SEL;
  wire [5:0] MULTIPLIER_VALUE;
  wire LOOP_ENABLE, LOOP_CLOCK_SELECTED;

  pcd_top #(.LOCK_REF_CYCLES(16'h0004)) i_dut (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA), .OSC_CLK(OSC_CLK), .VCO_CLK(VCO_CLK),
    .LOOP_REF_CLK(LOOP_REF_CLK), .LOOP_OUT_CLK(LOOP_OUT_CLK),
    .LOOP_FILTER_SEL(LOOP_FILTER_SEL), .VCO_RANGE_SEL(VCO_RANGE_SEL),
    .MULTIPLIER_VALUE(MULTIPLIER_VALUE), .LOOP_ENABLE(LOOP_ENABLE),
    .LOOP_CLOCK_SELECTED(LOOP_CLOCK_SELECTED),
    .LOOP_LOCKED(LOOP_LOCKED));

  // Core clock, and source pins off the rising core edges, still when off
  always #5 CORE_CLK = ~CORE_CLK;
  always #40 if (osc_on) OSC_CLK = ~OSC_CLK;
  always #30 if (osc_on) VCO_CLK = ~VCO_CLK;

  task check(input [31:0] seen, input [31:0] expv, input [95:0] what);
    begin
      n_compared = n_compared + 1;
      if (seen !== expv) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0s exp %h seen %h", what, expv, seen);
      end
    end
  endtask

  task summarize;
    begin
      if (n_errors == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // Single transfer, entered just after an edge; reads queue dv
  task xfer(input w, input [5:0] idx, input [7:0] dv);
    begin
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HWRITE <= w;
      HADDR <= {24'h0, idx, 2'b00};
      @(posedge CORE_CLK);
      while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
      HSEL <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= {24'h0, dv};
      if (!w) exp_q.push_back({24'h0, dv});
      @(posedge CORE_CLK);
      while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
    end
  endtask

  // Writable bits per index; unlisted places read zero
  function [7:0] msk(input integer k);
    case (k)
      0, 1, 6, 7: msk = 8'hff;
      2: msk = 8'h1f;
      4: msk = 8'h92;
      5: msk = 8'hcb;
      8: msk = 8'hc7;
      default: msk = 8'h00;
    endcase
  endfunction

  // Period of the third rise; first ones may still use old divisor
  task meas(input sel, output integer cyc);
    integer k, r;
    reg p, v;
    begin
      cyc = 0;
      r = 0;
      p = 1'b1;
      for (k = 0; k < 600 && r < 3; k = k + 1) begin
        @(posedge CORE_CLK);
        v = sel ? LOOP_OUT_CLK : LOOP_REF_CLK;
        if (r == 2) cyc = cyc + 1;
        if (v === 1'b1 && p === 1'b0) r = r + 1;
        p = v;
      end
    end
  endtask

  // Read data checked at the edge that ends the data phase
  always @(posedge CORE_CLK) begin
    if (rd_phase && HREADYOUT === 1'b1)
      check(HRDATA, exp_q.pop_front(), "read data");
    if (HREADYOUT === 1'b1) rd_phase <= HSEL && HTRANS[1] && !HWRITE;
  end

  // Watchdog well past the expected run length
  initial begin
    #200000;
    n_errors = n_errors + 1;
    summarize;
  end

  initial begin
    repeat (4) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    @(posedge CORE_CLK);
    for (i = 0; i < 14; i = i + 1)
      xfer(1'b0, i[5:0], i == 6 ? 8'h40 : 8'h00);
    xfer(1'b0, 6'h3f, 8'h00);
    for (i = 0; i < 14; i = i + 1) begin
      d = $random(seed);
      xfer(1'b1, i[5:0], d);
      xfer(1'b0, i[5:0], d & msk(i));
      // Control pins follow their fields once the read has completed
      if (i == 0)
        check({VCO_RANGE_SEL, MULTIPLIER_VALUE}, d, "mult out");
      if (i == 5)
        check(LOOP_CLOCK_SELECTED, d[7], "clock sel");
      if (i == 6)
        check(LOOP_ENABLE, d[6], "loop enable");
    end
    xfer(1'b1, 6'h05, 8'h00);
    xfer(1'b1, 6'h06, 8'h40);
    xfer(1'b1, 6'h01, 8'h80);
    xfer(1'b1, 6'h05, 8'h80);
    xfer(1'b1, 6'h01, 8'h7f);
    xfer(1'b0, 6'h01, 8'h80);
    check({30'h0, LOOP_FILTER_SEL}, 32'h2, "filter sel");
    xfer(1'b1, 6'h05, 8'h00);
    osc_on = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, 6'h01, {i[1:0], 4'h0, i[1:0]});
      meas(1'b0, c);
      check(c, 8 * (i + 1), "ref period");
      check({30'h0, LOOP_FILTER_SEL}, i, "filter sel");
    end
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, 6'h02, i[7:0]);
      meas(1'b1, c);
      check(c, i == 0 ? 6 : 12 * i, "out period");
    end
    xfer(1'b1, 6'h01, 8'h00);
    xfer(1'b0, 6'h03, 8'h00);
    for (i = 0; i < 300 && LOOP_LOCKED !== 1'b1; i = i + 1)
      @(posedge CORE_CLK);
    xfer(1'b0, 6'h03, 8'h08);
    xfer(1'b1, 6'h05, 8'h80);
    xfer(1'b1, 6'h01, 8'h01);
    xfer(1'b0, 6'h03, 8'h08);
    xfer(1'b0, 6'h01, 8'h00);
    summarize;
  end
endmodule

`default_nettype wire
